//--- pkg/rasp_pkg.sv
// Shared constants, types and register map of the raw ASCII serial port
package rasp_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int BAUD_TABLE [8] = '{300, 600, 900, 2400, 4800, 9600, 19200, 38400};
   localparam logic [7:0] XOFF_CHAR = 8'h13;
   localparam logic [7:0] XON_CHAR = 8'h11;
   // Register byte offsets
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_TXDATA = 12'h004;
   localparam logic [11:0] ADDR_STATUS = 12'h008;
   localparam logic [11:0] ADDR_IRQ_STAT = 12'h00C;
   localparam logic [11:0] ADDR_IRQ_MASK = 12'h010;
   localparam logic [11:0] ADDR_TIMING = 12'h014;
   localparam logic [11:0] ADDR_RXCOUNT = 12'h018;
   localparam logic [11:0] ADDR_BUFBASE = 12'h01C;
   localparam logic [2:0] MEM_REGION = 3'h1;
   // Interrupt bit positions
   localparam int IRQ_W = 6;
   localparam int IRQ_RX = 0;
   localparam int IRQ_PAR = 1;
   localparam int IRQ_FRM = 2;
   localparam int IRQ_TMO = 3;
   localparam int IRQ_TXD = 4;
   localparam int IRQ_OVF = 5;
   // Receive buffer
   localparam int MEM_DEPTH = 128;
   localparam int MEM_AW = 7;
   localparam int MEM_DW = 16;
   localparam logic [7:0] RX_MAX_BYTES = 8'h80;
   localparam int BUF_WORDS = 2 + 128 / 2;
   localparam logic [6:0] BUF_HDR_WORDS = 7'h02;
   localparam logic [6:0] BASE_MAX = 7'h3E;
   typedef enum logic [1:0] {PAR_NONE = 2'h0, PAR_EVEN = 2'h1, PAR_ODD = 2'h2} rasp_par_e;
   typedef enum logic [2:0] {
      TX_IDLE = 3'h0, TX_RTS_WAIT = 3'h1, TX_START = 3'h3, TX_DATA = 3'h2,
      TX_PAR = 3'h6, TX_STOP = 3'h7, TX_RTS_OFF = 3'h5
   } rasp_tx_e;
   typedef enum logic [2:0] {
      RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_PAR = 3'h2, RX_STOP = 3'h6
   } rasp_rx_e;
   typedef struct packed {
      logic en;
      logic echo_sup;
      logic rts_fc;
      logic xon_fc;
      rasp_par_e parity;
      logic stop2;
      logic data8;
      logic [2:0] baud;
   } rasp_cfg_s;
   localparam int CFG_W = 11;
   localparam rasp_cfg_s CFG_RESET = 11'h00D;
   typedef struct packed {
      logic [7:0] rts_off;
      logic [7:0] rts_on;
      logic [15:0] timeout;
   } rasp_tim_s;
   localparam rasp_tim_s TIM_RESET = 32'h0000_0000;
   typedef struct packed {
      logic en;
      logic [1:0] be;
      logic [MEM_AW-1:0] addr;
      logic [MEM_DW-1:0] data;
   } rasp_memwr_s;
endpackage

//--- src/rasp_buf_mem.sv
// Receive buffer memory: one byte-lane write port, one registered read port
`timescale 1ns/1ps
module rasp_buf_mem
   import rasp_pkg::*;
(
   input wire logic clk_in, // System clock
   input wire rasp_memwr_s wr_in, // Write request
   input wire logic [MEM_AW-1:0] rd_addr_in, // Read word address
   output logic [MEM_DW-1:0] rd_data_out // Registered read data
);
   typedef struct packed {
      logic [MEM_DEPTH-1:0][MEM_DW-1:0] words;
      logic [MEM_DW-1:0] rdata;
   } rasp_mem_state_s;

   rasp_mem_state_s s;
   rasp_mem_state_s n;

   always_comb
   begin
      n = s;
      n.rdata = s.words[rd_addr_in];
      if (wr_in.en && wr_in.be[0])
      begin
         n.words[wr_in.addr][7:0] = wr_in.data[7:0];
      end
      if (wr_in.en && wr_in.be[1])
      begin
         n.words[wr_in.addr][15:8] = wr_in.data[15:8];
      end
   end

   always_ff @(posedge clk_in)
   begin
      s <= n;
   end

   assign rd_data_out = s.rdata;
endmodule // rasp_buf_mem

//--- src/rasp_top.sv
// Raw ASCII serial port with AHB-Lite registers, flow control and receive buffer
`timescale 1ns/1ps
// Functional notes
// - Bit rate is selectable among 300, 600, 900, 2400, 4800, 9600, 19200 and 38400 baud.
// - All stations on the line must use one identical bit rate.
// - Seven or eight data bits are selectable and both ends must agree.
// - Frames end with one or two stop bits, matching the far end.
// - Parity is even, odd or absent, generated and checked, same at both ends.
// - With software flow control, sending stops after the pause character 13h arrives.
// - After a pause, sending resumes only when the resume character 11h arrives; the code also resumes when software flow control is switched off.
// - With hardware flow control, request-to-send is raised and sending waits for clear-to-send.
// - Flow control affects only transmission, never reception.
// - Received bytes go to a buffer at a set base, two header words plus half the bytes, 66 words.
// - Echo suppression keeps the port's own transmitted characters out of reception.
// - Line settings act only while the port option is enabled; otherwise the port is inactive.
// - After a message is sent, a missing response within the set interval logs an error.
// - A set delay elapses between raising request-to-send and sending.
// - A set delay elapses after the last data before request-to-send is released.
module rasp_top
   import rasp_pkg::*;
#(
   parameter int CLK_FREQ_HZ = CLK_HZ // Clock rate used to derive bit times
)(
   input wire logic clk_in, // System clock
   input wire logic rst_in, // Synchronous reset, active high
   input wire logic hsel_in, // AHB slave select
   input wire logic [31:0] haddr_in, // AHB address
   input wire logic [1:0] htrans_in, // AHB transfer type
   input wire logic hwrite_in, // AHB write
   input wire logic [2:0] hsize_in, // AHB size, word only
   input wire logic [31:0] hwdata_in, // AHB write data
   input wire logic hready_in, // AHB bus ready
   output logic hreadyout_out, // AHB slave ready
   output logic hresp_out, // AHB response, always OKAY
   output logic [31:0] hrdata_out, // AHB read data
   input wire logic serial_receive_line_in, // Serial receive pin
   input wire logic send_clear_input_in, // Clear-to-send pin, high is active
   output logic serial_transmit_line_out, // Serial transmit pin
   output logic send_request_output_out, // Request-to-send pin, high is active
   output logic irq_out // Level interrupt
);
   typedef struct packed {
      rasp_cfg_s cfg;
      rasp_tim_s tim;
      logic [IRQ_W-1:0] irq_stat;
      logic [IRQ_W-1:0] irq_mask;
      logic [MEM_AW-1:0] bufbase;
      logic [7:0] rx_count;
      logic dp_valid;
      logic dp_write;
      logic [11:0] dp_addr;
      logic [31:0] rdata;
      logic rx_m;
      logic rx_s;
      logic cts_m;
      logic cts_s;
      rasp_tx_e tx_st;
      logic [19:0] tx_div;
      logic [7:0] tx_hold;
      logic tx_full;
      logic [7:0] tx_sh;
      logic tx_par;
      logic [2:0] tx_bit;
      logic tx_stop2nd;
      logic tx_line;
      logic rts;
      logic [7:0] tx_cnt;
      logic paused;
      logic tmo_on;
      logic [15:0] tmo_cnt;
      rasp_rx_e rx_st;
      logic [19:0] rx_div;
      logic [7:0] rx_sh;
      logic [2:0] rx_bit;
      logic rx_perr;
      logic hdr_pend;
      rasp_memwr_s memwr;
   } rasp_top_state_s;

   rasp_top_state_s s;
   rasp_top_state_s n;
   logic [19:0] div;
   logic tx_tick;
   logic rx_tick;
   logic [2:0] last_bit;
   logic tx_busy;
   logic echo_block;
   logic go;
   logic rx_done;
   logic rx_good;
   logic [7:0] rx_byte;
   logic [MEM_DW-1:0] mem_rdata;

   function automatic logic [19:0] baud_div(input logic [2:0] sel);
      return 20'((CLK_FREQ_HZ + BAUD_TABLE[sel] / 2) / BAUD_TABLE[sel]);
   endfunction

   function automatic logic par_bit(input logic [7:0] d, input logic d8, input rasp_par_e p);
      return (^(d & {d8, 7'h7F})) ^ (p == PAR_ODD);
   endfunction

   function automatic rasp_top_state_s tx_load(input rasp_top_state_s st, input logic [19:0] d);
      rasp_top_state_s r;
      r = st;
      r.tx_sh = st.tx_hold;
      // Parity taken at load, since the holding byte may be refilled mid-frame
      r.tx_par = par_bit(st.tx_hold, st.cfg.data8, st.cfg.parity);
      r.tx_full = 1'b0;
      r.tx_div = d - 20'h00001;
      r.tx_line = 1'b0;
      r.tx_st = TX_START;
      return r;
   endfunction

   assign div = baud_div(s.cfg.baud);
   assign tx_tick = (s.tx_div == 20'h00000);
   assign rx_tick = (s.rx_div == 20'h00000);
   assign last_bit = s.cfg.data8 ? 3'h7 : 3'h6;
   assign tx_busy = (s.tx_st == TX_START) || (s.tx_st == TX_DATA) || (s.tx_st == TX_PAR)
      || (s.tx_st == TX_STOP);
   assign echo_block = s.cfg.echo_sup && tx_busy;
   assign go = s.cfg.en && s.tx_full && !s.paused;
   assign rx_done = (s.rx_st == RX_STOP) && rx_tick;
   assign rx_good = !s.rx_perr && s.rx_s;
   assign rx_byte = s.rx_sh & {s.cfg.data8, 7'h7F};

   always_comb
   begin
      logic [IRQ_W-1:0] ev;
      logic [IRQ_W-1:0] clr;
      logic [7:0] cnt_base;
      logic [MEM_AW-1:0] waddr;
      ev = '0;
      clr = '0;
      cnt_base = s.rx_count;
      waddr = '0;
      n = s;
      n.memwr.en = 1'b0;
      n.rx_m = serial_receive_line_in;
      n.rx_s = s.rx_m;
      n.cts_m = send_clear_input_in;
      n.cts_s = s.cts_m;
      // Bus data phase
      if (s.dp_valid && s.dp_write)
      begin
         case (s.dp_addr)
            ADDR_CTRL: n.cfg = rasp_cfg_s'(hwdata_in[CFG_W-1:0]);
            ADDR_TXDATA:
               if (!s.tx_full)
               begin
                  n.tx_hold = hwdata_in[7:0];
                  n.tx_full = 1'b1;
               end
            ADDR_IRQ_STAT: clr = hwdata_in[IRQ_W-1:0];
            ADDR_IRQ_MASK: n.irq_mask = hwdata_in[IRQ_W-1:0];
            ADDR_TIMING: n.tim = rasp_tim_s'(hwdata_in);
            ADDR_RXCOUNT:
            begin
               cnt_base = 8'h00;
               n.rx_count = 8'h00;
               n.hdr_pend = 1'b1;
            end
            ADDR_BUFBASE: n.bufbase = (hwdata_in[6:0] > BASE_MAX) ? BASE_MAX : hwdata_in[6:0];
            default: n.rx_count = s.rx_count;
         endcase
      end
      // Bus address phase
      n.dp_valid = hsel_in && htrans_in[1] && hready_in;
      n.dp_write = hwrite_in;
      n.dp_addr = haddr_in[11:0];
      case (haddr_in[11:0])
         ADDR_CTRL: n.rdata = {21'h000000, s.cfg};
         ADDR_STATUS: n.rdata = {27'h0000000, s.cts_s, s.rts, tx_busy, s.paused, s.tx_full};
         ADDR_IRQ_STAT: n.rdata = {26'h0000000, s.irq_stat};
         ADDR_IRQ_MASK: n.rdata = {26'h0000000, s.irq_mask};
         ADDR_TIMING: n.rdata = s.tim;
         ADDR_RXCOUNT: n.rdata = {24'h000000, s.rx_count};
         ADDR_BUFBASE: n.rdata = {25'h0000000, s.bufbase};
         default: n.rdata = 32'h0000_0000;
      endcase
      // Response timeout, counted in bit times
      n.tx_div = tx_tick ? div - 20'h00001 : s.tx_div - 20'h00001;
      if (s.tmo_on && tx_tick)
      begin
         n.tmo_cnt = s.tmo_cnt - 16'h0001;
         if (s.tmo_cnt == 16'h0001)
         begin
            n.tmo_on = 1'b0;
            ev[IRQ_TMO] = 1'b1;
         end
      end
      // Transmitter
      unique case (s.tx_st)
         TX_IDLE:
         begin
            n.tx_line = 1'b1;
            if (!s.cfg.rts_fc)
            begin
               n.rts = 1'b0;
            end
            if (go && s.cfg.rts_fc)
            begin
               n.rts = 1'b1;
               n.tx_cnt = s.rts ? 8'h00 : s.tim.rts_on;
               n.tx_st = TX_RTS_WAIT;
            end
            else if (go)
            begin
               n = tx_load(n, div);
            end
         end
         TX_RTS_WAIT:
            if (s.tx_cnt != 8'h00)
            begin
               if (tx_tick)
               begin
                  n.tx_cnt = s.tx_cnt - 8'h01;
               end
            end
            else if (s.cts_s && go)
            begin
               n = tx_load(n, div);
            end
         TX_START:
            if (tx_tick)
            begin
               n.tx_st = TX_DATA;
               n.tx_bit = 3'h0;
               n.tx_line = s.tx_sh[0];
            end
         TX_DATA:
            if (tx_tick)
            begin
               n.tx_sh = {1'b0, s.tx_sh[7:1]};
               n.tx_bit = s.tx_bit + 3'h1;
               n.tx_line = s.tx_sh[1];
               if (s.tx_bit == last_bit)
               begin
                  n.tx_stop2nd = 1'b0;
                  n.tx_st = (s.cfg.parity != PAR_NONE) ? TX_PAR : TX_STOP;
                  n.tx_line = (s.cfg.parity != PAR_NONE) ? s.tx_par : 1'b1;
               end
            end
         TX_PAR:
            if (tx_tick)
            begin
               n.tx_st = TX_STOP;
               n.tx_line = 1'b1;
            end
         TX_STOP:
            if (tx_tick)
            begin
               if (s.cfg.stop2 && !s.tx_stop2nd)
               begin
                  n.tx_stop2nd = 1'b1;
               end
               else
               begin
                  ev[IRQ_TXD] = 1'b1;
                  if (go && !s.cfg.rts_fc)
                  begin
                     n = tx_load(n, div);
                  end
                  else if (go)
                  begin
                     n.tx_cnt = 8'h00;
                     n.tx_st = TX_RTS_WAIT;
                  end
                  else
                  begin
                     n.tmo_on = (s.tim.timeout != 16'h0000);
                     n.tmo_cnt = s.tim.timeout;
                     n.tx_cnt = s.tim.rts_off;
                     n.tx_st = s.cfg.rts_fc ? TX_RTS_OFF : TX_IDLE;
                  end
               end
            end
         TX_RTS_OFF:
            if (go)
            begin
               n.tx_cnt = 8'h00;
               n.tx_st = TX_RTS_WAIT;
            end
            else if (s.tx_cnt == 8'h00)
            begin
               n.rts = 1'b0;
               n.tx_st = TX_IDLE;
            end
            else if (tx_tick)
            begin
               n.tx_cnt = s.tx_cnt - 8'h01;
            end
         default: n.tx_st = TX_IDLE;
      endcase
      // Receiver, never gated by flow control
      n.rx_div = rx_tick ? s.rx_div : s.rx_div - 20'h00001;
      unique case (s.rx_st)
         RX_IDLE:
            if (s.cfg.en && !s.rx_s && !echo_block)
            begin
               n.rx_st = RX_START;
               n.rx_div = {1'b0, div[19:1]};
               n.rx_sh = 8'h00;
               n.rx_perr = 1'b0;
            end
         RX_START:
            if (rx_tick)
            begin
               n.rx_st = s.rx_s ? RX_IDLE : RX_DATA;
               n.rx_bit = 3'h0;
               n.rx_div = div - 20'h00001;
            end
         RX_DATA:
            if (rx_tick)
            begin
               n.rx_sh[s.rx_bit] = s.rx_s;
               n.rx_bit = s.rx_bit + 3'h1;
               n.rx_div = div - 20'h00001;
               if (s.rx_bit == last_bit)
               begin
                  n.rx_st = (s.cfg.parity != PAR_NONE) ? RX_PAR : RX_STOP;
               end
            end
         RX_PAR:
            if (rx_tick)
            begin
               n.rx_perr = s.rx_s != par_bit(s.rx_sh, s.cfg.data8, s.cfg.parity);
               n.rx_div = div - 20'h00001;
               n.rx_st = RX_STOP;
            end
         RX_STOP:
            if (rx_tick)
            begin
               n.rx_st = RX_IDLE;
            end
         default: n.rx_st = RX_IDLE;
      endcase
      if (rx_done)
      begin
         ev[IRQ_RX] = 1'b1;
         ev[IRQ_PAR] = s.rx_perr;
         ev[IRQ_FRM] = !s.rx_s;
         n.tmo_on = 1'b0;
         if (rx_good && s.cfg.xon_fc && rx_byte == XOFF_CHAR)
         begin
            n.paused = 1'b1;
         end
         else if (rx_good && s.cfg.xon_fc && rx_byte == XON_CHAR)
         begin
            n.paused = 1'b0;
         end
         else if (rx_good && cnt_base < RX_MAX_BYTES)
         begin
            waddr = s.bufbase + BUF_HDR_WORDS + {1'b0, cnt_base[6:1]};
            n.memwr = '{1'b1, cnt_base[0] ? 2'b10 : 2'b01, waddr, {rx_byte, rx_byte}};
            n.rx_count = cnt_base + 8'h01;
            n.hdr_pend = 1'b1;
         end
         else if (rx_good)
         begin
            ev[IRQ_OVF] = 1'b1;
         end
      end
      if (!n.memwr.en && s.hdr_pend)
      begin
         n.memwr = '{1'b1, 2'b11, s.bufbase, {8'h00, n.rx_count}};
         n.hdr_pend = 1'b0;
      end
      if (!s.cfg.xon_fc)
      begin
         n.paused = 1'b0;
      end
      n.irq_stat = (s.irq_stat & ~clr) | ev;
   end

   always_ff @(posedge clk_in)
   begin
      if (rst_in)
      begin
         s <= '0;
         s.cfg <= CFG_RESET;
         s.tim <= TIM_RESET;
         s.tx_line <= 1'b1;
         s.rx_m <= 1'b1;
         s.rx_s <= 1'b1;
      end
      else
      begin
         s <= n;
      end
   end

   rasp_buf_mem u_mem (
      .clk_in(clk_in),
      .wr_in(s.memwr),
      .rd_addr_in(haddr_in[8:2]),
      .rd_data_out(mem_rdata)
   );

   assign hreadyout_out = 1'b1;
   assign hresp_out = 1'b0;
   assign hrdata_out = (s.dp_addr[11:9] == MEM_REGION) ? {16'h0000, mem_rdata} : s.rdata;
   assign serial_transmit_line_out = s.tx_line;
   assign send_request_output_out = s.rts;
   assign irq_out = |(s.irq_stat & s.irq_mask);

   default clocking cb @(posedge clk_in); endclocking
   default disable iff (rst_in);
   AST_IDLE_HIGH: assert property (s.tx_st == TX_IDLE |-> serial_transmit_line_out)
      else $error("line not idle high");
   AST_START_LOW: assert property (s.tx_st == TX_START |-> !serial_transmit_line_out)
      else $error("start bit not low");
   AST_STOP_HIGH: assert property (s.tx_st == TX_STOP |-> serial_transmit_line_out)
      else $error("stop bit not high");
   AST_NO_PAR: assert property (s.cfg.parity == PAR_NONE && s.tx_st == TX_DATA |=>
      s.tx_st != TX_PAR)
      else $error("parity sent while disabled");
   AST_XOFF_SET: assert property (rx_done && rx_good && s.cfg.xon_fc && rx_byte == XOFF_CHAR
      |=> s.paused ##1 (s.tx_st != TX_START || $past(s.tx_st) == TX_START))
      else $error("pause not taken");
   AST_XON_RESUME: assert property (rx_done && rx_good && s.cfg.xon_fc && rx_byte == XON_CHAR
      |=> !s.paused)
      else $error("resume not taken");
   AST_CTS_HOLD: assert property (s.tx_st == TX_RTS_WAIT && !s.cts_s |=> s.tx_st != TX_START)
      else $error("sent without clear-to-send");
   AST_RTS_UP: assert property (s.cfg.rts_fc && tx_busy |-> send_request_output_out)
      else $error("sending without request-to-send");
   AST_RX_FREE: assert property (s.rx_st == RX_IDLE && s.cfg.en && !s.rx_s && !echo_block
      |=> s.rx_st == RX_START)
      else $error("reception blocked");
   AST_ECHO: assert property (s.rx_st == RX_IDLE && echo_block |=> s.rx_st == RX_IDLE)
      else $error("own echo received");
   AST_BUF_LIMIT: assert property (s.memwr.en |->
      {1'b0, s.memwr.addr} < ({1'b0, s.bufbase} + 8'(BUF_WORDS)))
      else $error("write outside buffer");
   AST_TMO: assert property (s.tmo_on && tx_tick && s.tmo_cnt == 16'h0001 |=>
      s.irq_stat[IRQ_TMO])
      else $error("timeout not logged");
   AST_RTS_ON: assert property (s.tx_st == TX_RTS_WAIT && s.tx_cnt != 8'h00 |=>
      s.tx_st != TX_START)
      else $error("sent before on delay");
   AST_RTS_OFF: assert property (s.tx_st == TX_RTS_OFF && s.tx_cnt != 8'h00 |=>
      send_request_output_out)
      else $error("released before off delay");
   COV_FRAME: cover property (s.tx_st == TX_STOP ##1 s.tx_st == TX_IDLE);
   COV_PAUSE: cover property (s.paused && s.tx_full);
   COV_STORE: cover property (s.memwr.en && s.memwr.be != 2'b11);
   COV_TMO: cover property (s.irq_stat[IRQ_TMO]);
endmodule // rasp_top

//--- verif/rasp_peer.sv
// Far-end serial device model: sends frames to the port and captures its frames
`timescale 1ns/1ps
module rasp_peer
   import rasp_pkg::*;
#(
   parameter int DIV = 10 // Clock cycles per bit
)(
   input wire logic clk_in, // System clock
   input wire logic line_in, // Port transmit line
   output logic line_out, // Port receive line, idle high
   output logic cts_out // Clear-to-send to the port
);
   initial line_out = 1'h1;
   initial cts_out = 1'h0;

   task automatic bit_out(input logic v);
      line_out <= v;
      repeat (DIV) @(posedge clk_in);
   endtask

   // One frame to the port; bad flips the parity bit
   task automatic send(input logic [7:0] b, input rasp_cfg_s c, input logic bad);
      logic p;
      p = ^(c.data8 ? b : {1'h0, b[6:0]}) ^ (c.parity == PAR_ODD) ^ bad;
      @(posedge clk_in);
      bit_out(1'h0);
      for (int i = 0; i < (c.data8 ? 8 : 7); i++) bit_out(b[i]);
      if (c.parity != PAR_NONE) bit_out(p);
      bit_out(1'h1);
      if (c.stop2) bit_out(1'h1);
   endtask

   // Samples one frame mid-bit; ok is low on a bad start, parity or stop bit
   task automatic get(input rasp_cfg_s c, output logic [7:0] b, output logic ok);
      logic p;
      b = 8'h00;
      @(negedge line_in);
      repeat (DIV / 2) @(posedge clk_in);
      ok = (line_in === 1'h0);
      for (int i = 0; i < (c.data8 ? 8 : 7); i++)
      begin
         repeat (DIV) @(posedge clk_in);
         b[i] = line_in;
      end
      p = ^b ^ (c.parity == PAR_ODD);
      if (c.parity != PAR_NONE)
      begin
         repeat (DIV) @(posedge clk_in);
         ok &= (line_in === p);
      end
      repeat (c.stop2 ? 2 : 1)
      begin
         repeat (DIV) @(posedge clk_in);
         ok &= (line_in === 1'h1);
      end
   endtask

   // Clear-to-send level shown to the port
   task automatic set_cts(input logic v);
      cts_out <= v;
   endtask
endmodule // rasp_peer

//--- verif/rasp_top_test.sv
// Self-checking bench for the raw ASCII serial port
`timescale 1ns/1ps
`define CHK(n, e, s) begin checked++; if ((s) !== (e)) begin failures++; \
   $display("[FAIL] %s exp %h got %h", n, e, s); end end
module rasp_top_test
   import rasp_pkg::*;
;
   logic clk_in = 1'h0;
   logic rst_in = 1'h1;
   logic hsel = 1'h0;
   logic hwrite = 1'h0;
   logic [1:0] htrans = 2'h0;
   logic [31:0] haddr = 32'h0;
   logic [31:0] hwdata = 32'h0;
   logic [31:0] hrdata, rd;
   logic hready, hresp, tx, rx, cts, rts, irq, ok;
   logic [7:0] b;
   logic [31:0] cfgs [3] = '{32'h457, 32'h40F, 32'h42F};
   logic [7:0] txb [3] = '{8'h3C, 8'h55, 8'h41};
   logic [7:0] rxb [3] = '{8'h35, 8'h26, 8'h4C};
   int failures = 0;
   int checked = 0;
   int lows;

   rasp_top #(.CLK_FREQ_HZ(384000)) u_dut (.clk_in(clk_in), .rst_in(rst_in),
      .hsel_in(hsel), .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
      .hsize_in(3'h2), .hwdata_in(hwdata), .hready_in(hready), .hreadyout_out(hready),
      .hresp_out(hresp), .hrdata_out(hrdata), .serial_receive_line_in(rx),
      .send_clear_input_in(cts), .serial_transmit_line_out(tx),
      .send_request_output_out(rts), .irq_out(irq));
   rasp_peer #(.DIV(10)) u_peer (.clk_in(clk_in), .line_in(tx), .line_out(rx),
      .cts_out(cts));

   initial
   begin
      forever #5 clk_in = ~clk_in;
   end

   task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
      @(posedge clk_in);
      hsel <= 1'h1;
      htrans <= 2'h2;
      hwrite <= w;
      haddr <= {20'h0, a};
      do @(posedge clk_in); while (hready !== 1'h1);
      hsel <= 1'h0;
      htrans <= 2'h0;
      hwdata <= d;
      do @(posedge clk_in); while (hready !== 1'h1);
      rd = hrdata;
   endtask

   task automatic rdchk(input string n, input logic [11:0] a, input logic [31:0] e);
      xfer(1'h0, a, 32'h0);
      `CHK(n, e, rd)
   endtask

   // Counts cycles in which the transmit line left idle
   task automatic quiet(input int n);
      lows = 0;
      repeat (n)
      begin
         @(posedge clk_in);
         if (tx !== 1'h1) lows++;
      end
   endtask

   task automatic end_sim;
      if (failures == 0 && checked > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask

   initial
   begin
      #400000;
      failures++;
      end_sim();
   end

   initial
   begin
      repeat (20) @(posedge clk_in);
      rst_in <= 1'h0;
      rdchk("ctrl", ADDR_CTRL, 32'h0000_000D);
      rdchk("timing", ADDR_TIMING, 32'h0);
      xfer(1'h1, 12'h020, 32'hFFFF_FFFF);
      rdchk("unmapped", 12'h020, 32'h0);
      `CHK("resp", 1'h0, hresp)
      foreach (cfgs[i])
      begin
         xfer(1'h1, ADDR_CTRL, cfgs[i]);
         fork
            u_peer.get(cfgs[i][10:0], b, ok);
            xfer(1'h1, ADDR_TXDATA, {24'h0, txb[i]});
         join
         `CHK("tx byte", txb[i], b)
         `CHK("tx frame", 1'h1, ok)
         u_peer.send(rxb[i], cfgs[i][10:0], 1'h0);
      end
      rdchk("count", ADDR_RXCOUNT, 32'h3);
      xfer(1'h0, 12'h200, 32'h0);
      `CHK("header", 16'h0003, rd[15:0])
      xfer(1'h0, 12'h208, 32'h0);
      `CHK("word2", 16'h2635, rd[15:0])
      xfer(1'h0, 12'h20C, 32'h0);
      `CHK("word3", 8'h4C, rd[7:0])
      rdchk("irq stat", ADDR_IRQ_STAT, 32'h11);
      u_peer.send(8'h22, 11'h42F, 1'h1);
      rdchk("par err", ADDR_IRQ_STAT, 32'h13);
      rdchk("count", ADDR_RXCOUNT, 32'h3);
      `CHK("irq idle", 1'h0, irq)
      xfer(1'h1, ADDR_IRQ_MASK, 32'h2);
      #1 `CHK("irq set", 1'h1, irq)
      xfer(1'h1, ADDR_IRQ_STAT, 32'h2);
      #1 `CHK("irq clr", 1'h0, irq)
      xfer(1'h1, ADDR_CTRL, 32'h4AF);
      u_peer.send(XOFF_CHAR, 11'h42F, 1'h0);
      u_peer.send(8'h2A, 11'h42F, 1'h0);
      rdchk("paused", ADDR_STATUS, 32'h2);
      xfer(1'h1, ADDR_TXDATA, 32'h52);
      quiet(300);
      `CHK("held", 0, lows)
      rdchk("count", ADDR_RXCOUNT, 32'h4);
      fork
         u_peer.get(11'h42F, b, ok);
         u_peer.send(XON_CHAR, 11'h42F, 1'h0);
      join
      `CHK("resumed", 8'h52, b)
      xfer(1'h1, ADDR_TIMING, 32'h0002_0000);
      xfer(1'h1, ADDR_CTRL, 32'h52F);
      xfer(1'h1, ADDR_TXDATA, 32'h63);
      quiet(100);
      `CHK("cts wait", 0, lows)
      `CHK("rts", 1'h1, rts)
      fork
         u_peer.get(11'h42F, b, ok);
         u_peer.set_cts(1'h1);
      join
      `CHK("sent", 8'h63, b)
      repeat (20) @(posedge clk_in);
      `CHK("rts off", 1'h0, rts)
      xfer(1'h1, ADDR_IRQ_STAT, 32'h3F);
      xfer(1'h1, ADDR_TIMING, 32'h0000_0003);
      xfer(1'h1, ADDR_CTRL, 32'h60F);
      fork
         u_peer.get(11'h60F, b, ok);
         begin
            xfer(1'h1, ADDR_TXDATA, 32'h5A);
            repeat (20) @(posedge clk_in);
            u_peer.send(8'hFF, 11'h60F, 1'h0);
         end
      join
      `CHK("echo tx", 8'h5A, b)
      quiet(60);
      rdchk("echo cnt", ADDR_RXCOUNT, 32'h4);
      rdchk("timeout", ADDR_IRQ_STAT, 32'h18);
      end_sim();
   end
endmodule // rasp_top_test
